// ### pkg/plcad_consts.svh
`ifndef PLCAD_CONSTS_SVH
`define PLCAD_CONSTS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define PLCAD_CTRL_OFS 8'h00
`define PLCAD_STATUS_OFS 8'h04
`define PLCAD_ACTIVE_OFS 8'h08
`define PLCAD_PROG_OFS 8'h0C
`define PLCAD_SCANS_OFS 8'h10
`define PLCAD_RULE_BASE 8'h40

// ------------------------------------------------------------
// Control register fields and reset value
// ------------------------------------------------------------
`define PLCAD_CTRL_RUN 0
`define PLCAD_CTRL_DOUT1_SRC 1
`define PLCAD_CTRL_DOUT2_SRC 2
`define PLCAD_CTRL_RELAY1_SRC 3
`define PLCAD_CTRL_EXT_TRIP 4
`define PLCAD_CTRL_RESET 32'h0000_0000
`define PLCAD_RULE_RESET 32'h0000_0000

// ------------------------------------------------------------
// Rule configuration word fields
// ------------------------------------------------------------
`define PLCAD_RULE_CA_LSB 0
`define PLCAD_RULE_CB_LSB 8
`define PLCAD_RULE_OP_LSB 16
`define PLCAD_RULE_EN_BIT 19
`define PLCAD_RULE_ACT_LSB 24

// ------------------------------------------------------------
// Action codes
// ------------------------------------------------------------
`define PLCAD_ACT_W 32
`define PLCAD_ACT_DOUT1 0
`define PLCAD_ACT_DOUT2 1
`define PLCAD_ACT_RELAY1 2
`define PLCAD_ACT_DRV_EN 4
`define PLCAD_ACT_JOG_REV 5
`define PLCAD_ACT_JOG_FWD 6
`define PLCAD_ACT_STOP 8
`define PLCAD_ACT_JOG_EN 18
`define PLCAD_ACT_FAULT 19
`define PLCAD_ACT_FWD_EN 20
`define PLCAD_ACT_REV_EN 21
`define PLCAD_ACT_ACCDEC 22
`define PLCAD_ACT_RESET 23
`define PLCAD_ACT_PRESET 24
`define PLCAD_ACT_IDX0 25
`define PLCAD_ACT_IDX3 28
`define PLCAD_RESERVED_MASK 32'h0000_3E88

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define PLCAD_CLK_PERIOD_NS 10
`define PLCAD_SCAN_TIME_NS 1000000
`define PLCAD_SCAN_CYCLES \
  ((`PLCAD_SCAN_TIME_NS + `PLCAD_CLK_PERIOD_NS - 1) / `PLCAD_CLK_PERIOD_NS)

`endif

// ### pkg/plcad_pkg.sv
package plcad_pkg;

  // Logical operator applied to a rule's two input conditions
  typedef enum logic [2:0] {
    PLCAD_OP_OR = 3'h0,
    PLCAD_OP_AND = 3'h1,
    PLCAD_OP_XOR = 3'h2,
    PLCAD_OP_NOR = 3'h3,
    PLCAD_OP_NAND = 3'h4
  } plcad_op_t;

  typedef logic [7:0] plcad_code_t;
  typedef logic [31:0] plcad_word_t;

endpackage

// ### hdl/plcad_rule_eval.sv
`timescale 1ns/1ps
`include "plcad_consts.svh"

module plcad_rule_eval
  import plcad_pkg::*;
#(
  parameter int COND_W = 256
) (
  // Rule configuration and condition vector
  input wire plcad_word_t cfg_word,
  input wire logic [COND_W-1:0] cond_vec,
  // One-hot action decode
  output logic [`PLCAD_ACT_W-1:0] prog_vec,
  output logic [`PLCAD_ACT_W-1:0] act_vec
);

  // ------------------------------------------------------------
  // Field extraction
  // ------------------------------------------------------------
  wire plcad_code_t sel_a = cfg_word[`PLCAD_RULE_CA_LSB +: 8];
  wire plcad_code_t sel_b = cfg_word[`PLCAD_RULE_CB_LSB +: 8];
  wire logic [2:0] op_code = cfg_word[`PLCAD_RULE_OP_LSB +: 3];
  wire plcad_code_t act_code = cfg_word[`PLCAD_RULE_ACT_LSB +: 8];
  wire logic rule_on = cfg_word[`PLCAD_RULE_EN_BIT];
  // Out-of-range condition numbers read as false
  wire logic cond_a = (int'(sel_a) < COND_W) ? cond_vec[sel_a] : 1'b0;
  wire logic cond_b = (int'(sel_b) < COND_W) ? cond_vec[sel_b] : 1'b0;

  // Operator combine; undefined operator codes give false
  logic result;
  always_comb begin
    unique case (op_code)
      PLCAD_OP_OR: result = cond_a | cond_b;
      PLCAD_OP_AND: result = cond_a & cond_b;
      PLCAD_OP_XOR: result = cond_a ^ cond_b;
      PLCAD_OP_NOR: result = ~(cond_a | cond_b);
      PLCAD_OP_NAND: result = ~(cond_a & cond_b);
      default: result = 1'b0;
    endcase
  end

  // Codes above the decode range hit nothing, so they have no effect
  wire logic code_ok = act_code < 8'(`PLCAD_ACT_W);
  wire logic [`PLCAD_ACT_W-1:0] hit =
    code_ok ? (`PLCAD_ACT_W'(1) << act_code[4:0]) : '0;
  assign prog_vec = (rule_on ? hit : '0) & ~`PLCAD_RESERVED_MASK;
  assign act_vec = result ? prog_vec : '0;

endmodule

// ### hdl/plcad_dispatcher.sv
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "plcad_consts.svh"

// Overview of operation
// - Code 0 drives digital output one
// - Code 1 drives digital output two
// - Code 2 energises relay output one
// - Codes 3, 7, 9-13 reserved, no effect
// - Code 4 gates drive with hardware enable
// - Unprogrammed enable: hardware input alone decides
// - Codes 5/6 jog reverse/forward when allowed
// - Both jog requests active while jogging is allowed stops motor
// - Code 18 allows or blocks jogging
// - Code 8 stops motor while true
// - Code 19 raises rule engine fault
// - Codes 20/21 enable forward/reverse motion
// - Code 22 selects ramp group two
// - Code 23 resets on rising condition only
// - Code 24 selects preset speed source
// - No index bits programmed: first preset
// - Codes 25-27 set preset index bits
// - Combine conditions by OR/AND/XOR/NOR/NAND
// - Code 28 sets preset index bit three

module plcad_dispatcher
  import plcad_pkg::*;
#(
  parameter int NRULES = 8,
  parameter int COND_W = 256,
  parameter int SCAN_CYCLES = `PLCAD_SCAN_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data and response
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Conditions from the evaluator and drive inputs
  input wire logic [COND_W-1:0] cond_in,
  input wire logic hardware_enable_input,
  // Outputs and drive controls
  output logic dout1,
  output logic dout2,
  output logic relay1,
  output logic drive_enable,
  output logic stop_cmd,
  output logic jog_fwd,
  output logic jog_rev,
  output logic rule_engine_fault,
  output logic trip_conflict,
  output logic fwd_enable,
  output logic rev_enable,
  output logic accdec_group2,
  output logic reset_req,
  output logic speed_source_preset,
  output logic [3:0] preset_index
);

  localparam int RIDX_W = $clog2(NRULES);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  if (NRULES < 2 || NRULES > 16) begin : g_bad_rules
    $error("NRULES must lie between 2 and 16");
  end
  if (COND_W < 2 || COND_W > 256) begin : g_bad_cond
    $error("COND_W must lie between 2 and 256");
  end
  if (SCAN_CYCLES < 1) begin : g_bad_scan
    $error("SCAN_CYCLES must be at least 1");
  end

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  plcad_word_t ctrl_reg;
  plcad_word_t rule_cfg_reg [NRULES];
  plcad_word_t scans_reg;
  logic [31:0] scan_cnt_reg;
  logic [`PLCAD_ACT_W-1:0] act_mask_reg;
  logic [`PLCAD_ACT_W-1:0] prog_mask_reg;

  // ------------------------------------------------------------
  // AXI4-Lite write channel
  // ------------------------------------------------------------
  logic aw_full_reg;
  logic w_full_reg;
  logic [7:0] awaddr_reg;
  plcad_word_t wdata_reg;
  logic [3:0] wstrb_reg;

  // Address and data may arrive in either order; hold each until both are in
  wire logic aw_take = s_axi_awvalid & s_axi_awready;
  wire logic w_take = s_axi_wvalid & s_axi_wready;
  wire logic aw_have = aw_full_reg | aw_take;
  wire logic w_have = w_full_reg | w_take;
  wire logic do_write = aw_have & w_have & ~s_axi_bvalid;
  wire logic [7:0] wr_addr = aw_full_reg ? awaddr_reg : s_axi_awaddr;
  wire plcad_word_t wr_data = w_full_reg ? wdata_reg : s_axi_wdata;
  wire logic [3:0] wr_strb = w_full_reg ? wstrb_reg : s_axi_wstrb;
  wire logic aw_full_next = aw_have & ~do_write;
  wire logic w_full_next = w_have & ~do_write;
  wire logic bvalid_next = do_write | (s_axi_bvalid & ~s_axi_bready);

  // Write decode
  wire logic wr_ctrl = wr_addr == `PLCAD_CTRL_OFS;
  wire logic wr_rule_win = wr_addr[7:6] == 2'h1;
  wire logic [3:0] wr_rule_idx = wr_addr[5:2];
  wire logic wr_rule = wr_rule_win & (int'(wr_rule_idx) < NRULES);
  wire logic wr_ok = wr_ctrl | wr_rule;

  // Byte-lane merge of a write into an existing word
  function automatic plcad_word_t merge_strb(plcad_word_t old_w, plcad_word_t new_w,
                                             logic [3:0] strb);
    plcad_word_t res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Handshake flags; ready is registered so it comes from a flip-flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      s_axi_awready <= ~aw_full_next & ~bvalid_next;
      s_axi_wready <= ~w_full_next & ~bvalid_next;
      s_axi_bvalid <= bvalid_next;
      if (do_write) begin
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Held address and data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
    end
  end

  // Software-writable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `PLCAD_CTRL_RESET;
      for (int r = 0; r < NRULES; r++) begin
        rule_cfg_reg[r] <= `PLCAD_RULE_RESET;
      end
    end else if (do_write) begin
      if (wr_ctrl) begin
        ctrl_reg <= merge_strb(ctrl_reg, wr_data, wr_strb);
      end
      if (wr_rule) begin
        rule_cfg_reg[wr_rule_idx[RIDX_W-1:0]] <=
          merge_strb(rule_cfg_reg[wr_rule_idx[RIDX_W-1:0]], wr_data, wr_strb);
      end
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read channel
  // ------------------------------------------------------------
  wire logic ar_take = s_axi_arvalid & s_axi_arready;
  wire logic rvalid_next = ar_take | (s_axi_rvalid & ~s_axi_rready);
  wire logic [3:0] rd_rule_idx = s_axi_araddr[5:2];
  wire logic rd_rule = (s_axi_araddr[7:6] == 2'h1) & (int'(rd_rule_idx) < NRULES);
  wire plcad_word_t status_word = {14'h0000, hardware_enable_input, trip_conflict,
    preset_index, speed_source_preset, accdec_group2, rev_enable, fwd_enable,
    rule_engine_fault, jog_rev, jog_fwd, stop_cmd, drive_enable, relay1, dout2, dout1};
  wire logic rd_ctrl = s_axi_araddr == `PLCAD_CTRL_OFS;
  wire logic rd_status = s_axi_araddr == `PLCAD_STATUS_OFS;
  wire logic rd_active = s_axi_araddr == `PLCAD_ACTIVE_OFS;
  wire logic rd_prog = s_axi_araddr == `PLCAD_PROG_OFS;
  wire logic rd_scans = s_axi_araddr == `PLCAD_SCANS_OFS;
  wire logic rd_ok = rd_ctrl | rd_status | rd_active | rd_prog | rd_scans | rd_rule;
  wire plcad_word_t rd_data =
    rd_ctrl ? ctrl_reg :
    rd_status ? status_word :
    rd_active ? act_mask_reg :
    rd_prog ? prog_mask_reg :
    rd_scans ? scans_reg :
    rd_rule ? rule_cfg_reg[rd_rule_idx[RIDX_W-1:0]] : 32'h0000_0000;

  // One read in flight; data captured at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_next;
      s_axi_rvalid <= rvalid_next;
      if (ar_take) begin
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ------------------------------------------------------------
  // Rule evaluation
  // ------------------------------------------------------------
  logic [`PLCAD_ACT_W-1:0] prog_r [NRULES];
  logic [`PLCAD_ACT_W-1:0] act_r [NRULES];

  for (genvar r = 0; r < NRULES; r++) begin : g_rule
    plcad_rule_eval #(
      .COND_W(COND_W)
    ) u_eval (
      .cfg_word(rule_cfg_reg[r]),
      .cond_vec(cond_in),
      .prog_vec(prog_r[r]),
      .act_vec(act_r[r])
    );
  end

  // Several rules on one action are ORed together
  logic [`PLCAD_ACT_W-1:0] prog_any;
  logic [`PLCAD_ACT_W-1:0] act_any;
  always_comb begin
    prog_any = '0;
    act_any = '0;
    for (int r = 0; r < NRULES; r++) begin
      prog_any = prog_any | prog_r[r];
      act_any = act_any | act_r[r];
    end
  end

  // ------------------------------------------------------------
  // Scan tick
  // ------------------------------------------------------------
  wire logic run = ctrl_reg[`PLCAD_CTRL_RUN];
  wire logic scan_tick = run & (scan_cnt_reg == 32'(SCAN_CYCLES - 1));
  // Only the rising edge at a tick counts, so a chattering input
  // between ticks cannot issue extra resets
  wire logic rst_rise =
    scan_tick & act_any[`PLCAD_ACT_RESET] & ~act_mask_reg[`PLCAD_ACT_RESET];

  // Masks sample once per tick and hold; a stopped engine leaves defaults
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_cnt_reg <= 32'h0000_0000;
      scans_reg <= 32'h0000_0000;
      act_mask_reg <= '0;
      prog_mask_reg <= '0;
    end else if (!run) begin
      scan_cnt_reg <= 32'h0000_0000;
      act_mask_reg <= '0;
      prog_mask_reg <= '0;
    end else if (scan_tick) begin
      scan_cnt_reg <= 32'h0000_0000;
      scans_reg <= scans_reg + 32'h0000_0001;
      act_mask_reg <= act_any;
      prog_mask_reg <= prog_any;
    end else begin
      scan_cnt_reg <= scan_cnt_reg + 32'h0000_0001;
    end
  end

  // ------------------------------------------------------------
  // Action levels
  // ------------------------------------------------------------
  wire logic jog_allow =
    ~prog_mask_reg[`PLCAD_ACT_JOG_EN] | act_mask_reg[`PLCAD_ACT_JOG_EN];
  wire logic jog_rq_f = act_mask_reg[`PLCAD_ACT_JOG_FWD];
  wire logic jog_rq_r = act_mask_reg[`PLCAD_ACT_JOG_REV];
  wire logic jog_both = jog_allow & jog_rq_f & jog_rq_r;
  wire logic drv_gate =
    ~prog_mask_reg[`PLCAD_ACT_DRV_EN] | act_mask_reg[`PLCAD_ACT_DRV_EN];
  wire logic [3:0] idx_next =
    act_mask_reg[`PLCAD_ACT_IDX3:`PLCAD_ACT_IDX0];

  // Drive controls; enable follows the hardware input every cycle while the code 4 gate is open
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dout1 <= 1'b0;
      dout2 <= 1'b0;
      relay1 <= 1'b0;
      drive_enable <= 1'b0;
      stop_cmd <= 1'b0;
      jog_fwd <= 1'b0;
      jog_rev <= 1'b0;
      rule_engine_fault <= 1'b0;
      trip_conflict <= 1'b0;
    end else begin
      dout1 <= ctrl_reg[`PLCAD_CTRL_DOUT1_SRC] & act_mask_reg[`PLCAD_ACT_DOUT1];
      dout2 <= ctrl_reg[`PLCAD_CTRL_DOUT2_SRC] & act_mask_reg[`PLCAD_ACT_DOUT2];
      relay1 <= ctrl_reg[`PLCAD_CTRL_RELAY1_SRC] & act_mask_reg[`PLCAD_ACT_RELAY1];
      drive_enable <= hardware_enable_input & drv_gate;
      stop_cmd <= act_mask_reg[`PLCAD_ACT_STOP] | jog_both;
      jog_fwd <= jog_allow & jog_rq_f & ~jog_rq_r;
      jog_rev <= jog_allow & jog_rq_r & ~jog_rq_f;
      rule_engine_fault <= act_mask_reg[`PLCAD_ACT_FAULT];
      trip_conflict <= prog_mask_reg[`PLCAD_ACT_FAULT] & ctrl_reg[`PLCAD_CTRL_EXT_TRIP];
    end
  end

  // Direction, ramp, reset and speed source controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fwd_enable <= 1'b1;
      rev_enable <= 1'b1;
      accdec_group2 <= 1'b0;
      reset_req <= 1'b0;
      speed_source_preset <= 1'b0;
      preset_index <= 4'h0;
    end else begin
      fwd_enable <= ~prog_mask_reg[`PLCAD_ACT_FWD_EN] | act_mask_reg[`PLCAD_ACT_FWD_EN];
      rev_enable <= ~prog_mask_reg[`PLCAD_ACT_REV_EN] | act_mask_reg[`PLCAD_ACT_REV_EN];
      accdec_group2 <= act_mask_reg[`PLCAD_ACT_ACCDEC];
      reset_req <= rst_rise;
      speed_source_preset <= act_mask_reg[`PLCAD_ACT_PRESET];
      preset_index <= idx_next;
    end
  end

endmodule

// ### testbench/plcad_dispatcher_checker.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bus handshake and control output checks
// ----------------------------------------
module plcad_dispatcher_checker #(
  parameter int SCAN_CYCLES = 4
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus write side
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Bus read side
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Drive controls
  input wire logic hardware_enable_input,
  input wire logic drive_enable,
  input wire logic jog_fwd,
  input wire logic jog_rev,
  input wire logic reset_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Write and read answers one cycle after the take
  a_b_follows_take: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid) else $error("write response missing");
  a_r_follows_take: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  // Answers stand until the master accepts them
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  // No new write taken while a response waits
  a_ready_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready during response");
  a_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h20
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000) else $error("hole read wrong");
  // Power stage never allowed without the hardware pin
  a_drive_gated: assert property (drive_enable |-> $past(hardware_enable_input))
    else $error("drive enabled without pin");
  a_jog_single: assert property (!(jog_fwd && jog_rev))
    else $error("jog both ways");
  // Reset request is a lone pulse, followed by at least three low cycles
  a_reset_pulse: assert property (reset_req |=> !reset_req [*3])
    else $error("reset request too long");
endmodule

bind plcad_dispatcher plcad_dispatcher_checker #(.SCAN_CYCLES(SCAN_CYCLES)) u_chk (.*);

// ### testbench/plcad_drive_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Drive side: enable pin and reset tally
// ----------------------------------------
module plcad_drive_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench request and block pulse
  input wire logic en_req,
  input wire logic reset_req,
  // Pin and tally
  output logic hardware_enable_input,
  output logic [7:0] pulses
);
  // Pin lags the request one edge, like a synchronised input
  always_ff @(posedge aclk) begin
    hardware_enable_input <= en_req;
    if (!aresetn)
      pulses <= 8'h00;
    else if (reset_req)
      pulses <= pulses + 8'h01;
  end
endmodule

// ### testbench/plcad_dispatcher_tb_top.sv
`timescale 1ns/1ps
`include "plcad_consts.svh"
module plcad_dispatcher_tb_top;
  // Short scan keeps the run small
  localparam int SCAN = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, d;
  logic [255:0] cond_in = '0;
  logic hardware_enable_input, en_req = 1'b1;
  logic dout1, dout2, relay1, drive_enable, stop_cmd, jog_fwd, jog_rev, rule_engine_fault;
  logic trip_conflict, fwd_enable, rev_enable, accdec_group2, reset_req, speed_source_preset;
  logic [3:0] preset_index;
  logic [7:0] pulses;
  logic t;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  // Outputs in status register order
  wire [15:0] obs = {preset_index, speed_source_preset, accdec_group2, rev_enable, fwd_enable,
    rule_engine_fault, jog_rev, jog_fwd, stop_cmd, drive_enable, relay1, dout2, dout1};

  always #5 aclk = ~aclk;

  plcad_dispatcher #(.NRULES(8), .COND_W(256), .SCAN_CYCLES(SCAN)) dut (.*);

  plcad_drive_model drv (.aclk(aclk), .aresetn(aresetn), .en_req(en_req),
    .reset_req(reset_req), .hardware_enable_input(hardware_enable_input), .pulses(pulses));

  // ----------------------------------------
  // Reporting
  // ----------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------
  // Bus master tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    // Late ready exercises the response hold
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    v = s_axi_rdata;
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rw(input int c, input int op, input int a, input int b);
    return {c[7:0], 4'h0, 1'b1, op[2:0], b[7:0], a[7:0]};
  endfunction

  // Single rule on condition one, pin high, all sources on
  function automatic logic [15:0] exp_out(input int c, input logic v);
    logic [15:0] e;
    e = 16'h0308;
    case (c)
      0, 1, 2: e[c] = v;
      4: e[3] = v;
      5: e[6] = v;
      6: e[5] = v;
      8: e[4] = v;
      19: e[7] = v;
      20: e[8] = v;
      21: e[9] = v;
      22: e[10] = v;
      24: e[11] = v;
      25, 26, 27, 28: e[c - 13] = v;
      default: ;
    endcase
    return e;
  endfunction

  // Two scans cover tick plus output lag
  task automatic outs(input logic [15:0] e);
    logic [31:0] s;
    repeat (2 * SCAN + 2) @(posedge aclk);
    chk({16'h0000, obs}, {16'h0000, e});
    rd(`PLCAD_STATUS_OFS, s, 2'h0);
    chk({16'h0000, s[15:0]}, {16'h0000, e});
  endtask

  // ----------------------------------------
  // Hang guard
  // ----------------------------------------
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      close_out();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`PLCAD_CTRL_OFS, d, 2'h0);
    chk(d, 32'h0000_0000);
    // Holes, read-only and out-of-range rule are refused
    wr(8'h20, 32'h0000_0001, 2'h2);
    rd(8'h20, d, 2'h2);
    chk(d, 32'h0000_0000);
    wr(`PLCAD_STATUS_OFS, 32'h0000_FFFF, 2'h2);
    wr(8'h60, 32'h0000_0001, 2'h2);
    // Only the second byte lane lands
    s_axi_wstrb <= 4'h2;
    wr(`PLCAD_CTRL_OFS, 32'hFFFF_FF00, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(`PLCAD_CTRL_OFS, d, 2'h0);
    chk(d, 32'h0000_FF00);
    outs(16'h0308);
    wr(`PLCAD_CTRL_OFS, 32'h0000_000F, 2'h0);
    // Codes 0 to 28, true then false
    for (int c = 0; c < 29; c++) begin
      wr(`PLCAD_RULE_BASE, rw(c, 0, 1, 1), 2'h0);
      for (int v = 1; v >= 0; v--) begin
        @(posedge aclk);
        cond_in[1] <= v[0];
        outs(exp_out(c, v[0]));
      end
    end
    chk({24'h0, pulses}, 32'h0000_0001);
    // Both jogs stop, then jog gating
    wr(`PLCAD_RULE_BASE, rw(5, 0, 1, 1), 2'h0);
    wr(`PLCAD_RULE_BASE + 8'h04, rw(6, 0, 1, 1), 2'h0);
    cond_in[1] <= 1'b1;
    outs(16'h0318);
    wr(`PLCAD_RULE_BASE + 8'h04, rw(18, 0, 2, 2), 2'h0);
    outs(16'h0308);
    cond_in[2] <= 1'b1;
    outs(16'h0348);
    wr(`PLCAD_RULE_BASE + 8'h04, 32'h0000_0000, 2'h0);
    // Rule enable true but pin low
    wr(`PLCAD_RULE_BASE, rw(4, 0, 1, 1), 2'h0);
    en_req <= 1'b0;
    outs(16'h0300);
    en_req <= 1'b1;
    // Operators over all input pairs
    for (int op = 0; op < 5; op++) begin
      wr(`PLCAD_RULE_BASE, rw(0, op, 1, 2), 2'h0);
      for (int ab = 0; ab < 4; ab++) begin
        @(posedge aclk);
        cond_in[1] <= ab[0];
        cond_in[2] <= ab[1];
        case (op)
          0: t = ab[0] | ab[1];
          1: t = ab[0] & ab[1];
          2: t = ab[0] ^ ab[1];
          3: t = ~(ab[0] | ab[1]);
          default: t = ~(ab[0] & ab[1]);
        endcase
        outs({15'h0184, t});
      end
    end
    // Undefined operator code reads false though OR would be true
    wr(`PLCAD_RULE_BASE, rw(0, 5, 1, 2), 2'h0);
    outs(16'h0308);
    // Output source not given to the engine, condition true
    wr(`PLCAD_CTRL_OFS, 32'h0000_0001, 2'h0);
    wr(`PLCAD_RULE_BASE, rw(0, 0, 1, 1), 2'h0);
    outs(16'h0308);
    // Fault with external trip still selected
    wr(`PLCAD_CTRL_OFS, 32'h0000_001F, 2'h0);
    wr(`PLCAD_RULE_BASE, rw(19, 0, 1, 1), 2'h0);
    outs(16'h0388);
    chk({31'h0, trip_conflict}, 32'h0000_0001);
    close_out();
  end
endmodule
